// file: verilog/bjc_pkg.sv
// Package of offsets, field positions, reset values and decode tables for the boost config bank
package bjc_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NREG   = 3;

	// Register offsets
	localparam logic [7:0] SWITCH_FREQ_SEL_VOLTAGE_CFG_OFS = 8'hA6;
	localparam logic [7:0] BOOST_DRIVE_LIMIT_CFG_OFS  = 8'hA7;
	localparam logic [7:0] BOOST_MAX_JUMP_CFG_OFS     = 8'hA9;

	// Storage slot of each register
	localparam logic [1:0] IDX_FREQ_VOLTAGE = 2'h0;
	localparam logic [1:0] IDX_DRIVE_LIMIT  = 2'h1;
	localparam logic [1:0] IDX_MAX_JUMP     = 2'h2;

	// Reset values
	localparam logic [7:0] SWITCH_FREQ_SEL_VOLTAGE_CFG_RST = 8'h00;
	localparam logic [7:0] BOOST_DRIVE_LIMIT_CFG_RST  = 8'h00;
	localparam logic [7:0] BOOST_MAX_JUMP_CFG_RST     = 8'h00;

	// Writable bits; reserved bits are not stored and read as zero
	localparam logic [7:0] SWITCH_FREQ_SEL_VOLTAGE_CFG_MASK = 8'hFF;
	localparam logic [7:0] BOOST_DRIVE_LIMIT_CFG_MASK  = 8'h33;
	localparam logic [7:0] BOOST_MAX_JUMP_CFG_MASK     = 8'hFF;

	// Field positions
	localparam int unsigned SWITCH_FREQ_SEL_LSB     = 6;
	localparam int unsigned OUTPUT_VOLTAGE_CODE_LSB = 0;
	localparam int unsigned GATE_DRIVER_C_BIT       = 5;
	localparam int unsigned GATE_DRIVER_B_BIT       = 4;
	localparam int unsigned CURRENT_LIMIT_SEL_LSB   = 0;
	localparam int unsigned MAX_VOLTAGE_SEL_LSB     = 5;
	localparam int unsigned JUMP_ENABLE_BIT         = 4;
	localparam int unsigned JUMP_THRESHOLD_LSB      = 2;
	localparam int unsigned JUMP_VOLTAGE_LSB        = 0;

	// Switching frequency in kHz for codes 00..10; 11 is undefined
	localparam logic [10:0] FREQ_KHZ [3] = '{11'h138, 11'h271, 11'h4E2};
	localparam logic [1:0]  FREQ_CODE_UNDEF = 2'h3;

	// Inductor current limit in mA, single and doubled
	localparam logic [11:0] ILIM_MA_1X [4] = '{12'h384, 12'h4B0, 12'h5DC, 12'h708};
	localparam logic [11:0] ILIM_MA_2X [4] = '{12'h640, 12'h834, 12'hA28, 12'h000};
	localparam logic [1:0]  ILIM_CODE_NO_2X = 2'h3;

	// Maximum boost voltage in 100 mV units, by code; zero marks no value
	localparam logic [8:0] VMAX_HI_DV [8] = '{9'h000, 9'h000, 9'h0D2, 9'h0FA,
		9'h12C, 9'h159, 9'h186, 9'h1AE};
	localparam logic [8:0] VMAX_LO_DV [8] = '{9'h000, 9'h000, 9'h000, 9'h000,
		9'h0D2, 9'h0FA, 9'h12C, 9'h154};

	// Jump threshold in percent and jump step in mV
	localparam logic [6:0]  JUMP_PCT [4] = '{7'h0A, 7'h1E, 7'h32, 7'h46};
	localparam logic [11:0] JUMP_MV  [4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hFA0};

endpackage : bjc_pkg

// file: verilog/bjc_cfg_store.sv
// Small word store for the config registers with registered read data
`timescale 1ns/1ns

module bjc_cfg_store #(
	parameter int unsigned            NREG  = 3,
	parameter int unsigned            W     = 8,
	parameter logic [NREG*W-1:0]      RST   = '0,
	parameter logic [NREG*W-1:0]      WMASK = '1
) (
	input  wire logic                 clk_sys,
	input  wire logic                 resetn,
	input  wire logic                 wr_en,
	input  wire logic [1:0]           wr_idx,
	input  wire logic [W-1:0]         wr_data,
	input  wire logic                 rd_en,
	input  wire logic                 rd_hit,
	input  wire logic [1:0]           rd_idx,
	output logic      [W-1:0]         rd_data,
	output logic      [NREG*W-1:0]    cfg_flat
);

	typedef struct packed {
		logic [NREG*W-1:0] mem;
		logic [W-1:0]      rdata;
	} bjc_store_t;

	bjc_store_t st_q;
	bjc_store_t st_d;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		st_d = st_q;
		// Read data stands only in the cycle after the strobe
		st_d.rdata = '0;
		for (int i = 0; i < NREG; i++)
		begin
			if (wr_en && (wr_idx == 2'(i)))
			begin
				st_d.mem[i*W +: W] = wr_data & WMASK[i*W +: W];
			end
			if (rd_en && rd_hit && (rd_idx == 2'(i)))
			begin
				st_d.rdata = st_q.mem[i*W +: W];
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			st_q.mem   <= RST & WMASK;
			st_q.rdata <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign rd_data  = st_q.rdata;
	assign cfg_flat = st_q.mem;

endmodule : bjc_cfg_store

// file: verilog/bjc_boost_jump_cfg.sv
// Boost converter and jump detection configuration register bank with field decode
// Function
// - With the external frequency-set enable low, the 2-bit code picks 312, 625 or 1250 kHz and code 11 has no frequency.
// - Bits 5:0 set the boost voltage code, which is also start and floor voltage under adaptive control.
// - Bits 5 and 4 each switch one extra boost gate driver on or off to set slew rate.
// - The 2-bit limit code picks 0.9/1.2/1.5/1.8 A, or 1.6/2.1/2.6 A when doubling is on.
// - Bits 7:5 pick the maximum boost voltage from the high or the low range table.
// - With jump enable set, PWM duty jumps are detected at a 10, 30, 50 or 70 percent threshold.
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ns

module bjc_boost_jump_cfg #(
	parameter int unsigned ADDR_W = bjc_pkg::ADDR_W,
	parameter int unsigned DATA_W = bjc_pkg::DATA_W
) (
	input  wire logic              clk_sys,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              resistor_freq_set_enable,
	input  wire logic              adaptive_enable,
	input  wire logic              output_range_sel,
	input  wire logic              current_limit_double,
	output logic                   freq_from_register,
	output logic      [1:0]        switch_freq_sel,
	output logic      [10:0]       switch_freq_khz,
	output logic                   switch_freq_undefined,
	output logic      [5:0]        output_voltage_code,
	output logic      [5:0]        boost_floor_code,
	output logic                   gate_driver_c_enable,
	output logic                   gate_driver_b_enable,
	output logic      [1:0]        inductor_current_limit_sel,
	output logic      [11:0]       current_limit_ma,
	output logic                   current_limit_illegal,
	output logic      [2:0]        max_output_voltage_sel,
	output logic      [8:0]        max_voltage_dv,
	output logic                   max_voltage_illegal,
	output logic                   jump_enable,
	output logic      [6:0]        jump_threshold_pct,
	output logic      [11:0]       jump_step_mv
);

	typedef struct packed {
		logic        fset_s1;
		logic        fset_s2;
		logic        freq_reg;
		logic [1:0]  freq_sel;
		logic [10:0] freq_khz;
		logic        freq_undef;
		logic [5:0]  vcode;
		logic [5:0]  floor;
		logic        drv_c;
		logic        drv_b;
		logic [1:0]  ilim_sel;
		logic [11:0] ilim_ma;
		logic        ilim_bad;
		logic [2:0]  vmax_sel;
		logic [8:0]  vmax_dv;
		logic        vmax_bad;
		logic        jump_en;
		logic [6:0]  jump_pct;
		logic [11:0] jump_mv;
	} bjc_state_t;

	localparam logic [bjc_pkg::NREG*DATA_W-1:0] RST_ALL = {
		bjc_pkg::BOOST_MAX_JUMP_CFG_RST,
		bjc_pkg::BOOST_DRIVE_LIMIT_CFG_RST,
		bjc_pkg::SWITCH_FREQ_SEL_VOLTAGE_CFG_RST};
	localparam logic [bjc_pkg::NREG*DATA_W-1:0] MASK_ALL = {
		bjc_pkg::BOOST_MAX_JUMP_CFG_MASK,
		bjc_pkg::BOOST_DRIVE_LIMIT_CFG_MASK,
		bjc_pkg::SWITCH_FREQ_SEL_VOLTAGE_CFG_MASK};

	bjc_state_t                        st_q;
	bjc_state_t                        st_d;
	logic                              hit;
	logic [1:0]                        idx;
	logic [bjc_pkg::NREG*DATA_W-1:0]   cfg_flat;
	logic [DATA_W-1:0]                 r_fv;
	logic [DATA_W-1:0]                 r_dl;
	logic [DATA_W-1:0]                 r_mj;

	////////////////////////////////////////////////////////////////////////////////
	// Address decode; unmapped addresses ignore writes and read as zero
	always_comb
	begin
		hit = 1'b1;
		idx = bjc_pkg::IDX_FREQ_VOLTAGE;
		case (reg_addr)
			bjc_pkg::SWITCH_FREQ_SEL_VOLTAGE_CFG_OFS: idx = bjc_pkg::IDX_FREQ_VOLTAGE;
			bjc_pkg::BOOST_DRIVE_LIMIT_CFG_OFS:  idx = bjc_pkg::IDX_DRIVE_LIMIT;
			bjc_pkg::BOOST_MAX_JUMP_CFG_OFS:     idx = bjc_pkg::IDX_MAX_JUMP;
			default:                             hit = 1'b0;
		endcase
	end

	bjc_cfg_store #(
		.NREG   (bjc_pkg::NREG),
		.W      (DATA_W),
		.RST    (RST_ALL),
		.WMASK  (MASK_ALL)
	) u_store (
		.clk_sys  (clk_sys),
		.resetn   (resetn),
		.wr_en    (reg_wr && hit),
		.wr_idx   (idx),
		.wr_data  (reg_wdata),
		.rd_en    (reg_rd),
		.rd_hit   (hit),
		.rd_idx   (idx),
		.rd_data  (reg_rdata),
		.cfg_flat (cfg_flat)
	);

	assign r_fv = cfg_flat[bjc_pkg::IDX_FREQ_VOLTAGE*DATA_W +: DATA_W];
	assign r_dl = cfg_flat[bjc_pkg::IDX_DRIVE_LIMIT*DATA_W +: DATA_W];
	assign r_mj = cfg_flat[bjc_pkg::IDX_MAX_JUMP*DATA_W +: DATA_W];

	////////////////////////////////////////////////////////////////////////////////
	// Field decode; every output lags a register write by one cycle
	always_comb
	begin
		st_d = st_q;
		// Frequency-set strap comes from a pin, so it is synchronised first
		st_d.fset_s1 = resistor_freq_set_enable;
		st_d.fset_s2 = st_q.fset_s1;

		st_d.freq_sel   = r_fv[bjc_pkg::SWITCH_FREQ_SEL_LSB +: 2];
		st_d.freq_reg   = !st_q.fset_s2;
		st_d.freq_undef = st_d.freq_reg && (st_d.freq_sel == bjc_pkg::FREQ_CODE_UNDEF);
		st_d.freq_khz   = '0;
		if (st_d.freq_reg && !st_d.freq_undef)
		begin
			st_d.freq_khz = bjc_pkg::FREQ_KHZ[st_d.freq_sel];
		end

		st_d.vcode = r_fv[bjc_pkg::OUTPUT_VOLTAGE_CODE_LSB +: 6];
		st_d.floor = adaptive_enable ? st_d.vcode : 6'h00;

		st_d.drv_c = r_dl[bjc_pkg::GATE_DRIVER_C_BIT];
		st_d.drv_b = r_dl[bjc_pkg::GATE_DRIVER_B_BIT];

		st_d.ilim_sel = r_dl[bjc_pkg::CURRENT_LIMIT_SEL_LSB +: 2];
		st_d.ilim_ma  = bjc_pkg::ILIM_MA_1X[st_d.ilim_sel];
		if (current_limit_double)
		begin
			st_d.ilim_ma = bjc_pkg::ILIM_MA_2X[st_d.ilim_sel];
		end
		// forbidden combination flagged
		// The table yields 0 mA there, so the analog side keeps its own safe default
		st_d.ilim_bad = current_limit_double && (st_d.ilim_sel == bjc_pkg::ILIM_CODE_NO_2X);

		st_d.vmax_sel = r_mj[bjc_pkg::MAX_VOLTAGE_SEL_LSB +: 3];
		st_d.vmax_dv  = output_range_sel ? bjc_pkg::VMAX_HI_DV[st_d.vmax_sel]
			: bjc_pkg::VMAX_LO_DV[st_d.vmax_sel];
		st_d.vmax_bad = (st_d.vmax_dv == 9'h000);

		st_d.jump_en  = r_mj[bjc_pkg::JUMP_ENABLE_BIT];
		st_d.jump_pct = bjc_pkg::JUMP_PCT[r_mj[bjc_pkg::JUMP_THRESHOLD_LSB +: 2]];
		st_d.jump_mv  = bjc_pkg::JUMP_MV[r_mj[bjc_pkg::JUMP_VOLTAGE_LSB +: 2]];
	end

	always_ff @(posedge clk_sys)
	begin
		if (!resetn)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Doubling bit lives in another bank on this clock, so it enters unsynchronised
	// and lands in the limit decode with the same one-cycle lag as the fields here

	assign freq_from_register         = st_q.freq_reg;
	assign switch_freq_sel            = st_q.freq_sel;
	assign switch_freq_khz            = st_q.freq_khz;
	assign switch_freq_undefined      = st_q.freq_undef;
	assign output_voltage_code        = st_q.vcode;
	assign boost_floor_code           = st_q.floor;
	assign gate_driver_c_enable       = st_q.drv_c;
	assign gate_driver_b_enable       = st_q.drv_b;
	assign inductor_current_limit_sel = st_q.ilim_sel;
	assign current_limit_ma           = st_q.ilim_ma;
	assign current_limit_illegal      = st_q.ilim_bad;
	assign max_output_voltage_sel     = st_q.vmax_sel;
	assign max_voltage_dv             = st_q.vmax_dv;
	assign max_voltage_illegal        = st_q.vmax_bad;
	assign jump_enable                = st_q.jump_en;
	assign jump_threshold_pct         = st_q.jump_pct;
	assign jump_step_mv               = st_q.jump_mv;

endmodule : bjc_boost_jump_cfg

// file: verilog/README_unused.sv
// Intentionally empty
`timescale 1ns/1ns

// file: verif/bjc_cfg_props.sv
// Concurrent checks on the boost and jump config bank ports
`timescale 1ns/1ns

module bjc_cfg_props (
	input wire logic        clk_sys,
	input wire logic        resetn,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        adaptive_enable,
	input wire logic        output_range_sel,
	input wire logic        current_limit_double,
	input wire logic        freq_from_register,
	input wire logic [1:0]  switch_freq_sel,
	input wire logic [10:0] switch_freq_khz,
	input wire logic [5:0]  output_voltage_code,
	input wire logic [5:0]  boost_floor_code,
	input wire logic        gate_driver_c_enable,
	input wire logic        gate_driver_b_enable,
	input wire logic [1:0]  inductor_current_limit_sel,
	input wire logic [11:0] current_limit_ma,
	input wire logic [2:0]  max_output_voltage_sel,
	input wire logic [8:0]  max_voltage_dv,
	input wire logic        jump_enable,
	input wire logic [6:0]  jump_threshold_pct,
	input wire logic [11:0] jump_step_mv
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!resetn);

	////////////////////////////////////////////////////////////////
	// Lone write; a second write right behind it would move the decode
	sequence s_wr(logic [7:0] a);
		reg_wr && reg_addr == a ##1 !(reg_wr && reg_addr == a);
	endsequence

	property p_rd_idle;
		!reg_rd |=> reg_rdata == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
	property p_unmapped;
		reg_rd && !(reg_addr inside {8'hA6, 8'hA7, 8'hA9}) |=> reg_rdata == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_freq_wr;
		s_wr(8'hA6) |=> switch_freq_sel == $past(reg_wdata[7:6], 2)
			&& output_voltage_code == $past(reg_wdata[5:0], 2);
	endproperty
	a_freq_wr: assert property (p_freq_wr) else $error("freq or voltage field");
	property p_freq_khz;
		freq_from_register && switch_freq_sel != 2'h3
			|-> switch_freq_khz == bjc_pkg::FREQ_KHZ[switch_freq_sel];
	endproperty
	a_freq_khz: assert property (p_freq_khz) else $error("frequency decode");
	property p_floor;
		adaptive_enable && $past(adaptive_enable) |-> boost_floor_code == output_voltage_code;
	endproperty
	a_floor: assert property (p_floor) else $error("floor code");
	property p_drive_wr;
		s_wr(8'hA7) |=> {gate_driver_c_enable, gate_driver_b_enable} == $past(reg_wdata[5:4], 2);
	endproperty
	a_drive_wr: assert property (p_drive_wr) else $error("gate driver enables");
	// Reset values still stand at the first edge after release, hence the guard
	property p_ilim;
		$past(resetn) |-> current_limit_ma == ($past(current_limit_double)
			? bjc_pkg::ILIM_MA_2X[inductor_current_limit_sel]
			: bjc_pkg::ILIM_MA_1X[inductor_current_limit_sel]);
	endproperty
	a_ilim: assert property (p_ilim) else $error("current limit decode");
	property p_jump_wr;
		s_wr(8'hA9) |=> jump_enable == $past(reg_wdata[4], 2)
			&& jump_threshold_pct == bjc_pkg::JUMP_PCT[$past(reg_wdata[3:2], 2)]
			&& jump_step_mv == bjc_pkg::JUMP_MV[$past(reg_wdata[1:0], 2)];
	endproperty
	a_jump_wr: assert property (p_jump_wr) else $error("jump fields");
	property p_vmax_hi;
		output_range_sel && $past(output_range_sel)
			|-> max_voltage_dv == bjc_pkg::VMAX_HI_DV[max_output_voltage_sel];
	endproperty
	a_vmax_hi: assert property (p_vmax_hi) else $error("high range decode");
endmodule : bjc_cfg_props

bind bjc_boost_jump_cfg bjc_cfg_props u_props (
	.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
	.adaptive_enable, .output_range_sel, .freq_from_register, .switch_freq_sel,
	.switch_freq_khz, .output_voltage_code, .boost_floor_code, .gate_driver_c_enable,
	.gate_driver_b_enable, .current_limit_double, .inductor_current_limit_sel, .current_limit_ma,
	.max_output_voltage_sel, .max_voltage_dv, .jump_enable,
	.jump_threshold_pct, .jump_step_mv
);

// file: verif/bjc_boost_jump_cfg_tb.sv
// Self-checking bench for the boost and jump config bank
`timescale 1ns/1ns

module bjc_boost_jump_cfg_tb;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        resistor_freq_set_enable = 1'b0;
	logic        adaptive_enable = 1'b0;
	logic        output_range_sel = 1'b0;
	logic        current_limit_double = 1'b0;
	logic [7:0]  reg_rdata;
	logic        freq_from_register, switch_freq_undefined, current_limit_illegal;
	logic        gate_driver_c_enable, gate_driver_b_enable, max_voltage_illegal, jump_enable;
	logic [1:0]  switch_freq_sel, inductor_current_limit_sel;
	logic [10:0] switch_freq_khz;
	logic [5:0]  output_voltage_code, boost_floor_code;
	logic [11:0] current_limit_ma, jump_step_mv;
	logic [2:0]  max_output_voltage_sel;
	logic [8:0]  max_voltage_dv;
	logic [6:0]  jump_threshold_pct;
	int          err_total = 0;
	int          checked = 0;

	bjc_boost_jump_cfg u_dut (
		.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.resistor_freq_set_enable, .adaptive_enable, .output_range_sel, .current_limit_double,
		.freq_from_register,
		.switch_freq_sel, .switch_freq_khz, .switch_freq_undefined, .output_voltage_code,
		.boost_floor_code, .gate_driver_c_enable, .gate_driver_b_enable,
		.inductor_current_limit_sel, .current_limit_ma, .current_limit_illegal,
		.max_output_voltage_sel, .max_voltage_dv, .max_voltage_illegal, .jump_enable,
		.jump_threshold_pct, .jump_step_mv
	);

	always #25 clk_sys = ~clk_sys;

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			err_total++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk({4'h0, reg_rdata}, {4'h0, e}, "readback");
	endtask : rd

	// Decode outputs land one edge after the write edge; settle waits two
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		#1;
	endtask : settle

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(8'hA6, 8'h00);
		rd(8'hA7, 8'h00);
		rd(8'hA9, 8'h00);
		chk(12'(switch_freq_khz), 12'h138, "reset freq"); // lowest frequency
	endtask : t_reset

	task automatic t_freq;
		for (int c = 0; c < 4; c++)
		begin
			wr(8'hA6, {c[1:0], 6'h2A});
			settle();
			chk(12'(switch_freq_sel), 12'(c), "freq code"); // code field
			chk(12'(switch_freq_khz), (c == 3) ? 12'h000 : 12'(bjc_pkg::FREQ_KHZ[c]), "khz"); // table
			chk(12'(switch_freq_undefined), 12'(c == 3), "undef"); // undefined code
		end
		@(posedge clk_sys);
		resistor_freq_set_enable <= 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		chk({10'h000, freq_from_register, switch_freq_undefined}, 12'h000, "strap"); // pin wins
		chk(12'(switch_freq_khz), 12'h000, "strap khz"); // no register frequency
		@(posedge clk_sys);
		resistor_freq_set_enable <= 1'b0;
	endtask : t_freq

	task automatic t_volt;
		wr(8'hA6, 8'h2A);
		rd(8'hA6, 8'h2A); // voltage field readback
		chk(12'(output_voltage_code), 12'h02A, "vcode"); // voltage code
		chk(12'(boost_floor_code), 12'h000, "floor off"); // floor only when adaptive
		@(posedge clk_sys);
		adaptive_enable <= 1'b1;
		settle();
		chk(12'(boost_floor_code), 12'h02A, "floor on"); // floor equals code
	endtask : t_volt

	task automatic t_drive;
		wr(8'hA7, 8'hFF);
		rd(8'hA7, 8'h33); // reserved bits read zero
		chk({10'h000, gate_driver_c_enable, gate_driver_b_enable}, 12'h003, "drivers on"); // both
		wr(8'hA7, 8'h10);
		settle();
		chk({10'h000, gate_driver_c_enable, gate_driver_b_enable}, 12'h001, "drivers"); // enables
		for (int c = 0; c < 4; c++)
		begin
			wr(8'hA7, 8'(c));
			settle();
			chk(current_limit_ma, bjc_pkg::ILIM_MA_1X[c], "limit"); // single table
			chk(12'(inductor_current_limit_sel), 12'(c), "limit code"); // code field
			chk(12'(current_limit_illegal), 12'h000, "limit flag"); // no doubling
		end
		// code 11 cleared before doubling and never written with it
		wr(8'hA7, 8'h00);
		@(posedge clk_sys);
		current_limit_double <= 1'b1;
		for (int c = 0; c < 3; c++)
		begin
			wr(8'hA7, 8'(c));
			settle();
			chk(current_limit_ma, bjc_pkg::ILIM_MA_2X[c], "limit 2x"); // doubled table
			chk(12'(current_limit_illegal), 12'h000, "limit 2x flag"); // legal code
		end
		@(posedge clk_sys);
		current_limit_double <= 1'b0;
	endtask : t_drive

	task automatic t_max;
		for (int r = 0; r < 2; r++)
		begin
			@(posedge clk_sys);
			output_range_sel <= r[0];
			for (int c = 0; c < 8; c++)
			begin
				// low range never gets codes 010 and 011
				if (r == 0 && (c == 2 || c == 3))
					continue;
				wr(8'hA9, {c[2:0], c[0], c[1:0], c[2:1]});
				settle();
				chk(12'(max_output_voltage_sel), 12'(c), "vmax code"); // code field
				chk(12'(max_voltage_dv), 12'(r[0] ? bjc_pkg::VMAX_HI_DV[c] :
					bjc_pkg::VMAX_LO_DV[c]), "vmax"); // range tables
				chk(12'(max_voltage_illegal), 12'(c < (r[0] ? 2 : 4)), "vmax flag"); // no value
				chk(12'(jump_enable), 12'(c[0]), "jump en"); // enable bit
				chk(12'(jump_threshold_pct), 12'(bjc_pkg::JUMP_PCT[c[1:0]]), "thr"); // threshold
				chk(jump_step_mv, bjc_pkg::JUMP_MV[c[2:1]], "step"); // voltage step
			end
		end
	endtask : t_max

	task automatic t_unmapped;
		wr(8'hA8, 8'hFF);
		rd(8'hA8, 8'h00); // unmapped reads zero
		rd(8'hA6, 8'h2A); // neighbour untouched
	endtask : t_unmapped

	task automatic close_out;
		if (err_total == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : close_out

	initial
	begin
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		t_reset();
		t_freq();
		t_volt();
		t_drive();
		t_max();
		t_unmapped();
		close_out();
	end
endmodule : bjc_boost_jump_cfg_tb
